//--- logic/rcrb_bank.sv
`timescale 1ns/1ns
`include "rcrb_regs.svh"
module rcrb_bank
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // fuse preset values, stable during reset
   input wire logic [7:0] fuse_buck2_limit,
   input wire logic [7:0] fuse_buck3_run,
   input wire logic [7:0] fuse_buck3_stby,
   input wire logic [7:0] fuse_buck3_slp,
   input wire logic [7:0] fuse_buck3_ctrl,
   input wire logic [7:0] fuse_buck3_limit,
   input wire logic [7:0] fuse_backup,
   input wire logic [7:0] fuse_memref,
   input wire logic [7:0] fuse_lin1_lvl,
   input wire logic [7:0] fuse_lin1_ctrl,
   input wire logic [7:0] fuse_lin2_lvl,
   input wire logic [7:0] fuse_lin2_ctrl,
   input wire logic [7:0] fuse_lin3_lvl,
   input wire logic [7:0] fuse_lin3_ctrl,
   // system voltage below undervoltage threshold, asynchronous
   input wire logic undervoltage_threshold,
   // axi4-lite write address
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // regulator controls
   output logic buck2_current_limit_q_o1,
   output logic buck2_current_limit_q_o0,
   output logic buck2_timing_select,
   output logic [1:0] buck3_current_limit,
   output logic buck3_timing_select,
   output logic [3:0] buck3_level,
   output logic buck3_on,
   output logic buck3_low_power,
   output logic buck3_forced_switching,
   output logic buck3_discharge_on,
   output logic supply_select_on,
   output logic backup_bandgap_off,
   output logic memref_on,
   output logic memref_low_power,
   output logic [14:0] linreg_level,
   output logic [2:0] linreg_on,
   output logic [2:0] linreg_low_power,
   output logic [1:0] linreg_switch_mode
);
   localparam int NREG = 15;
   logic [7:0] reg_q [NREG];
   logic [7:0] fuse [NREG];
   logic [7:0] offs [NREG];
   logic [7:0] wmask [NREG];
   logic [7:0] rmask [NREG];
   logic uv_s1_q;
   logic uv_s2_q;
   logic aw_have_q;
   logic w_have_q;
   logic [8:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   rcrb_pkg::rcrb_wfsm_t wfsm_q;
   rcrb_pkg::rcrb_state_t pstate;
   logic do_write;
   logic rd_hit;
   logic wr_hit;
   logic [7:0] rd_val;
   logic [3:0] hit_idx;
   logic rst_d1_q;

   assign fuse = '{
      fuse_buck2_limit,
      fuse_buck3_run,
      fuse_buck3_stby,
      fuse_buck3_slp,
      fuse_buck3_ctrl,
      fuse_buck3_limit,
      fuse_backup,
      fuse_memref,
      fuse_lin1_lvl,
      fuse_lin1_ctrl,
      fuse_lin2_lvl,
      fuse_lin2_ctrl,
      fuse_lin3_lvl,
      fuse_lin3_ctrl,
      8'h00
   };
   assign offs = '{
      `RCRB_OFF_BUCK2_LIMIT,
      `RCRB_OFF_BUCK3_RUN,
      `RCRB_OFF_BUCK3_STBY,
      `RCRB_OFF_BUCK3_SLP,
      `RCRB_OFF_BUCK3_CTRL,
      `RCRB_OFF_BUCK3_LIMIT,
      `RCRB_OFF_BACKUP,
      `RCRB_OFF_MEMREF,
      `RCRB_OFF_LIN1_LVL,
      `RCRB_OFF_LIN1_CTRL,
      `RCRB_OFF_LIN2_LVL,
      `RCRB_OFF_LIN2_CTRL,
      `RCRB_OFF_LIN3_LVL,
      `RCRB_OFF_LIN3_CTRL,
      `RCRB_OFF_POWER_STATE
   };
   // buck3 levels writable-mask zero: no dynamic scaling on that rail
   assign wmask = '{
      `RCRB_MASK_LIMIT,
      8'h00,
      8'h00,
      8'h00,
      `RCRB_MASK_BUCK3_CTRL,
      `RCRB_MASK_LIMIT,
      `RCRB_MASK_BACKUP,
      `RCRB_MASK_MEMREF,
      `RCRB_MASK_LVL5,
      `RCRB_MASK_LIN13_CTRL,
      `RCRB_MASK_LVL4,
      `RCRB_MASK_LIN2_CTRL,
      `RCRB_MASK_LVL5,
      `RCRB_MASK_LIN13_CTRL,
      `RCRB_MASK_STATE
   };
   assign rmask = '{
      `RCRB_MASK_LIMIT,
      `RCRB_MASK_LVL4,
      `RCRB_MASK_LVL4,
      `RCRB_MASK_LVL4,
      `RCRB_MASK_BUCK3_CTRL,
      `RCRB_MASK_LIMIT,
      `RCRB_MASK_BACKUP,
      `RCRB_MASK_MEMREF,
      `RCRB_MASK_LVL5,
      `RCRB_MASK_LIN13_CTRL,
      `RCRB_MASK_LVL4,
      `RCRB_MASK_LIN2_CTRL,
      `RCRB_MASK_LVL5,
      `RCRB_MASK_LIN13_CTRL,
      `RCRB_MASK_STATE
   };

   always_ff @(posedge aclk)
   begin
      uv_s1_q <= undervoltage_threshold;
      uv_s2_q <= uv_s1_q;
   end

   // write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 9'h000;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         wfsm_q <= rcrb_pkg::RCRB_W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RCRB_RESP_OKAY;
      end
      else
      begin
         case (wfsm_q)
            rcrb_pkg::RCRB_W_IDLE:
            begin
               if (s_axi_awvalid && s_axi_awready)
               begin
                  aw_have_q <= 1'b1;
                  awaddr_q <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready)
               begin
                  w_have_q <= 1'b1;
                  wdata_q <= s_axi_wdata[7:0];
                  wstrb0_q <= s_axi_wstrb[0];
               end
               if (do_write)
               begin
                  wfsm_q <= rcrb_pkg::RCRB_W_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? `RCRB_RESP_OKAY : `RCRB_RESP_SLVERR;
               end
            end
            rcrb_pkg::RCRB_W_RESP:
            begin
               aw_have_q <= 1'b0;
               w_have_q <= 1'b0;
               if (s_axi_bready)
               begin
                  s_axi_bvalid <= 1'b0;
                  wfsm_q <= rcrb_pkg::RCRB_W_IDLE;
               end
            end
            default:
               wfsm_q <= rcrb_pkg::RCRB_W_IDLE;
         endcase
      end
   end

   assign s_axi_awready = (wfsm_q == rcrb_pkg::RCRB_W_IDLE) && !aw_have_q && aresetn;
   assign s_axi_wready = (wfsm_q == rcrb_pkg::RCRB_W_IDLE) && !w_have_q && aresetn;
   assign do_write = (wfsm_q == rcrb_pkg::RCRB_W_IDLE) && aw_have_q && w_have_q;

   always_comb
   begin
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      rd_val = 8'h00;
      hit_idx = 4'h0;
      // offsets are word indices, so the byte address is four times one
      for (int i = 0; i < NREG; i++)
      begin
         if (awaddr_q[8:2] == offs[i][6:0] && awaddr_q[1:0] == 2'b00)
         begin
            wr_hit = 1'b1;
            hit_idx = 4'(i);
         end
         if (s_axi_araddr[8:2] == offs[i][6:0] && s_axi_araddr[1:0] == 2'b00)
         begin
            rd_hit = 1'b1;
            rd_val = reg_q[i] & rmask[i];
         end
      end
   end

   // per-register storage with fuse preset
   for (genvar g = 0; g < NREG; g++)
   begin : g_reg
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            reg_q[g] <= 8'h00;
         else if (rst_d1_q)
            reg_q[g] <= fuse[g] & rmask[g];
         else if (do_write && wr_hit && wstrb0_q && hit_idx == 4'(g))
         begin
            // switch mode bit may only be raised on linreg 1/3
            if (g == 9 || g == 13)
               reg_q[g] <= (wdata_q & wmask[g]) | (reg_q[g] & 8'h10);
            else
               reg_q[g] <= (wdata_q & wmask[g]) | (reg_q[g] & ~wmask[g]);
         end
      end
   end

   // fuse load one edge after reset release so no port feeds a reset value
   always_ff @(posedge aclk)
      rst_d1_q <= !aresetn;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RCRB_RESP_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_val};
         s_axi_rresp <= rd_hit ? `RCRB_RESP_OKAY : `RCRB_RESP_SLVERR;
      end
   end
   assign s_axi_arready = aresetn && !s_axi_rvalid;

   assign pstate = rcrb_pkg::rcrb_state_t'(reg_q[14][1:0]);

   // regulator outputs registered from the bank one edge after a write, buck3_discharge_on one edge after buck3_on
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         buck2_current_limit_q_o1 <= 1'b0;
         buck2_current_limit_q_o0 <= 1'b0;
         buck2_timing_select <= 1'b0;
         buck3_current_limit <= 2'b00;
         buck3_timing_select <= 1'b0;
         buck3_level <= 4'h0;
         buck3_on <= 1'b0;
         buck3_low_power <= 1'b0;
         buck3_forced_switching <= 1'b0;
         buck3_discharge_on <= 1'b0;
         supply_select_on <= 1'b0;
         backup_bandgap_off <= 1'b0;
         memref_on <= 1'b0;
         memref_low_power <= 1'b0;
         linreg_level <= 15'h0000;
         linreg_on <= 3'b000;
         linreg_low_power <= 3'b000;
         linreg_switch_mode <= 2'b00;
      end
      else
      begin
         {buck2_current_limit_q_o1, buck2_current_limit_q_o0} <= reg_q[0][1:0];
         buck2_timing_select <= reg_q[0][4];
         buck3_current_limit <= reg_q[5][1:0];
         buck3_timing_select <= reg_q[5][4];
         case (pstate)
            rcrb_pkg::RCRB_STANDBY:
            begin
               buck3_level <= reg_q[2][3:0];
               buck3_on <= reg_q[4][`RCRB_BIT_STBY];
               memref_on <= reg_q[7][`RCRB_BIT_EN] & reg_q[7][`RCRB_BIT_STBY];
               for (int k = 0; k < 3; k++)
                  linreg_on[k] <= reg_q[9 + 2 * k][`RCRB_BIT_STBY];
            end
            rcrb_pkg::RCRB_SLEEP:
            begin
               buck3_level <= reg_q[3][3:0];
               buck3_on <= reg_q[4][`RCRB_BIT_SLP];
               memref_on <= reg_q[7][`RCRB_BIT_EN] & reg_q[7][`RCRB_BIT_SLP];
               for (int k = 0; k < 3; k++)
                  linreg_on[k] <= reg_q[9 + 2 * k][`RCRB_BIT_SLP];
            end
            default:
            begin
               buck3_level <= reg_q[1][3:0];
               buck3_on <= reg_q[4][`RCRB_BIT_EN];
               memref_on <= reg_q[7][`RCRB_BIT_EN];
               for (int k = 0; k < 3; k++)
                  linreg_on[k] <= reg_q[9 + 2 * k][`RCRB_BIT_EN];
            end
         endcase
         buck3_low_power <= reg_q[4][`RCRB_BIT_LPWR] && pstate != rcrb_pkg::RCRB_RUN;
         for (int k = 0; k < 3; k++)
            linreg_low_power[k] <= reg_q[9 + 2 * k][`RCRB_BIT_LPWR] &&
               pstate != rcrb_pkg::RCRB_RUN;
         buck3_forced_switching <= reg_q[4][`RCRB_BIT_FORCED_CONTINUOUS_SWITCHING];
         // resistor only when off and bit 7 low
         buck3_discharge_on <= !reg_q[4][`RCRB_BIT_RDIS_N] && !buck3_on;
         // level bits 2:0 and eval bit 3 drive nothing
         supply_select_on <= reg_q[6][`RCRB_BIT_FORCE_BOS] | uv_s2_q;
         backup_bandgap_off <= reg_q[6][`RCRB_BIT_BG_DIS];
         memref_low_power <= reg_q[7][`RCRB_BIT_LPWR];
         linreg_level <= {reg_q[12][4:0], 1'b0, reg_q[10][3:0], reg_q[8][4:0]};
         linreg_switch_mode <= {reg_q[13][`RCRB_BIT_SWITCH], reg_q[9][`RCRB_BIT_SWITCH]};
      end
   end
endmodule

//--- logic/rcrb_pkg.sv
package rcrb_pkg;
   typedef enum logic [1:0] {
      RCRB_RUN = 2'b00,
      RCRB_STANDBY = 2'b01,
      RCRB_SLEEP = 2'b11
   } rcrb_state_t;
   typedef enum logic [1:0] {
      RCRB_W_IDLE = 2'b00,
      RCRB_W_RESP = 2'b01
   } rcrb_wfsm_t;
endpackage

//--- logic/rcrb_regs.svh
`ifndef RCRB_REGS_SVH
`define RCRB_REGS_SVH
`define RCRB_OFF_BUCK2_LIMIT 8'h3c
`define RCRB_OFF_BUCK3_RUN 8'h3e
`define RCRB_OFF_BUCK3_STBY 8'h3f
`define RCRB_OFF_BUCK3_SLP 8'h40
`define RCRB_OFF_BUCK3_CTRL 8'h41
`define RCRB_OFF_BUCK3_LIMIT 8'h42
`define RCRB_OFF_BACKUP 8'h48
`define RCRB_OFF_MEMREF 8'h4a
`define RCRB_OFF_LIN1_LVL 8'h4c
`define RCRB_OFF_LIN1_CTRL 8'h4d
`define RCRB_OFF_LIN2_LVL 8'h4f
`define RCRB_OFF_LIN2_CTRL 8'h50
`define RCRB_OFF_LIN3_LVL 8'h52
`define RCRB_OFF_LIN3_CTRL 8'h53
`define RCRB_OFF_POWER_STATE 8'h70
`define RCRB_MASK_LIMIT 8'h13
`define RCRB_MASK_LVL4 8'h0f
`define RCRB_MASK_LVL5 8'h1f
`define RCRB_MASK_BUCK3_CTRL 8'hcf
`define RCRB_MASK_BACKUP 8'h3f
`define RCRB_MASK_MEMREF 8'h0f
`define RCRB_MASK_LIN13_CTRL 8'h1f
`define RCRB_MASK_LIN2_CTRL 8'h0f
`define RCRB_MASK_STATE 8'h03
`define RCRB_BIT_EN 0
`define RCRB_BIT_STBY 1
`define RCRB_BIT_SLP 2
`define RCRB_BIT_LPWR 3
`define RCRB_BIT_SWITCH 4
`define RCRB_BIT_FORCE_BOS 4
`define RCRB_BIT_BG_DIS 5
`define RCRB_BIT_FORCED_CONTINUOUS_SWITCHING 6
`define RCRB_BIT_RDIS_N 7
`define RCRB_RESP_OKAY 2'b00
`define RCRB_RESP_SLVERR 2'b10
`endif

//--- verification/rcrb_bank_asserts.sv
`timescale 1ns/1ns
`include "rcrb_regs.svh"
module rcrb_bank_asserts
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // regulator side
   input wire logic undervoltage_threshold,
   input wire logic buck3_on,
   input wire logic buck3_discharge_on,
   input wire logic supply_select_on,
   input wire logic [14:0] linreg_level,
   input wire logic [1:0] linreg_switch_mode
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // synchroniser history is unknown until a few cycles after release
   logic [2:0] live_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         live_q <= 3'h0;
      else if (live_q != 3'h7)
         live_q <= live_q + 3'h1;
   end
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_read_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_misaligned_err: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[1:0] != 2'b00 |=> s_axi_rresp == `RCRB_RESP_SLVERR)
      else $error("misaligned read not refused");
   a_supply_follows: assert property ((live_q == 3'h7 && undervoltage_threshold) [*4]
      |-> supply_select_on)
      else $error("supply selection ignores undervoltage");
   a_switch_sticky: assert property (!$fell(linreg_switch_mode[0])
      && !$fell(linreg_switch_mode[1]))
      else $error("switch mode cleared");
   a_discharge_off: assert property (buck3_on && $past(buck3_on) |-> !buck3_discharge_on)
      else $error("discharge while buck on");
   a_level_gap: assert property (linreg_level[9] == 1'b0)
      else $error("level gap bit set");
   c_error_read: cover property (s_axi_rvalid && s_axi_rresp == `RCRB_RESP_SLVERR);
   c_supply_rise: cover property ($rose(supply_select_on));
   c_write_done: cover property (s_axi_bvalid);
endmodule
bind rcrb_bank rcrb_bank_asserts rcrb_bank_asserts_i (.*);

//--- verification/test_rcrb_bank.sv
`timescale 1ns/1ns
`include "rcrb_regs.svh"
module test_rcrb_bank;
   logic aclk = 1'b0, aresetn = 1'b0, undervoltage_threshold = 1'b0;
   logic [13:0][7:0] fv = {8'h15, 8'h3f, 8'hf3, 8'hf9, 8'h10, 8'hee, 8'h0b, 8'hff, 8'h12,
      8'h4c, 8'ha5, 8'h3a, 8'h0c, 8'hff};
   logic [8:0] s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
   logic [7:0] d;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic buck2_current_limit_q_o1, buck2_current_limit_q_o0, buck2_timing_select;
   logic [1:0] buck3_current_limit, linreg_switch_mode;
   logic buck3_timing_select, buck3_on, buck3_low_power, buck3_forced_switching;
   logic [3:0] buck3_level;
   logic buck3_discharge_on, supply_select_on, backup_bandgap_off, memref_on, memref_low_power;
   logic [14:0] linreg_level;
   logic [2:0] linreg_on, linreg_low_power;
   int mismatches, checks, cycles, k;

   rcrb_bank rcrb_bank_i (.*, .fuse_buck2_limit(fv[0]), .fuse_buck3_run(fv[1]),
      .fuse_buck3_stby(fv[2]), .fuse_buck3_slp(fv[3]), .fuse_buck3_ctrl(fv[4]),
      .fuse_buck3_limit(fv[5]), .fuse_backup(fv[6]), .fuse_memref(fv[7]),
      .fuse_lin1_lvl(fv[8]), .fuse_lin1_ctrl(fv[9]), .fuse_lin2_lvl(fv[10]),
      .fuse_lin2_ctrl(fv[11]), .fuse_lin3_lvl(fv[12]), .fuse_lin3_ctrl(fv[13]));

   initial
   begin
      forever #50 aclk = ~aclk;
   end

   task automatic stop_test;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         stop_test;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // register offsets are word indices on the bus
   function automatic logic [8:0] ba(input logic [7:0] i);
      return {i[6:0], 2'b00};
   endfunction

   // ready and valid are looked at on the falling edge, acted on at the next rising one
   task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] v);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
         q = s_axi_rdata;
         rsp = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ta)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (tw)
            s_axi_wvalid <= 1'b0;
         if (tb)
         begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] v,
      input logic [1:0] r = `RCRB_RESP_OKAY);
      bus(1'b1, a, v);
      chk(32'(rsp), 32'(r));
   endtask

   task automatic rd(input logic [8:0] a, input logic [7:0] e,
      input logic [1:0] r = `RCRB_RESP_OKAY);
      bus(1'b0, a, 8'h0);
      chk(32'(rsp), 32'(r));
      if (r == `RCRB_RESP_OKAY)
         chk(q, 32'(e));
   endtask

   task automatic rst_chk;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(32'({buck3_on, buck3_forced_switching, buck3_discharge_on}),
         32'({fv[4][0], fv[4][6], ~fv[4][7] & ~fv[4][0]}));
      chk(32'({memref_on, memref_low_power, linreg_on, linreg_switch_mode}), 32'({fv[7][0],
         fv[7][3], fv[13][0], fv[11][0], fv[9][0], fv[13][4], fv[9][4]}));
      chk(32'(linreg_level), 32'({fv[12][4:0], 1'b0, fv[10][3:0], fv[8][4:0]}));
      chk(32'({buck3_current_limit, buck3_timing_select, buck3_level}),
         32'({fv[5][1:0], fv[5][4], fv[1][3:0]}));
      rd(ba(`RCRB_OFF_BUCK2_LIMIT), fv[0] & 8'h13);
      rd(ba(`RCRB_OFF_BUCK3_RUN), fv[1] & 8'h0f);
      rd(ba(`RCRB_OFF_BUCK3_SLP), fv[3] & 8'h0f);
      rd(ba(`RCRB_OFF_BUCK3_CTRL), fv[4] & 8'hcf);
      rd(ba(`RCRB_OFF_BACKUP), fv[6] & 8'h3f);
      rd(ba(`RCRB_OFF_MEMREF), fv[7] & 8'h0f);
      rd(ba(`RCRB_OFF_LIN1_LVL), fv[8] & 8'h1f);
      rd(ba(`RCRB_OFF_LIN2_CTRL), fv[11] & 8'h0f);
      rd(ba(`RCRB_OFF_LIN3_CTRL), fv[13] & 8'h1f);
   endtask

   initial
   begin
      rst_chk;
      for (k = 0; k < 4; k++)
      begin
         d = {3'h7, k[0], 2'h3, k[1:0]};
         wr(ba(`RCRB_OFF_BUCK2_LIMIT), d);
         @(negedge aclk);
         chk(32'({buck2_current_limit_q_o1, buck2_current_limit_q_o0, buck2_timing_select}),
            32'({k[1:0], k[0]}));
         rd(ba(`RCRB_OFF_BUCK2_LIMIT), d & 8'h13);
      end
      s_axi_wstrb <= 4'he;
      wr(ba(`RCRB_OFF_BUCK2_LIMIT), 8'h00);
      s_axi_wstrb <= 4'hf;
      rd(ba(`RCRB_OFF_BUCK2_LIMIT), 8'h13);
      wr(ba(`RCRB_OFF_BUCK3_SLP), 8'hff);
      rd(ba(`RCRB_OFF_BUCK3_SLP), fv[3] & 8'h0f);
      wr(ba(`RCRB_OFF_BACKUP), 8'hf0);
      @(negedge aclk);
      chk(32'({supply_select_on, backup_bandgap_off}), 32'h3);
      rd(ba(`RCRB_OFF_BACKUP), 8'h30);
      wr(ba(`RCRB_OFF_BACKUP), 8'h0f);
      for (k = 0; k < 3; k++)
      begin
         undervoltage_threshold <= k[0];
         repeat (6) @(posedge aclk);
         @(negedge aclk);
         chk(32'({supply_select_on, backup_bandgap_off}), 32'({k[0], 1'b0}));
         @(posedge aclk);
      end
      d = 8'h0a;
      wr(ba(`RCRB_OFF_LIN2_CTRL), d);
      for (k = 0; k < 3; k++)
      begin
         wr(ba(`RCRB_OFF_POWER_STATE), {6'h0, k[1], |k[1:0]});
         @(negedge aclk);
         chk(32'({linreg_on[1], linreg_low_power[1], buck3_on, buck3_low_power}),
            32'({d[k], k != 0, fv[4][k], fv[4][3] && k != 0}));
         chk(32'({buck3_level, memref_on}), 32'({fv[k + 1][3:0], fv[7][0] & fv[7][k]}));
      end
      wr(ba(`RCRB_OFF_POWER_STATE), 8'h00);
      wr(ba(`RCRB_OFF_LIN1_LVL), 8'hff);
      @(negedge aclk);
      chk(32'(linreg_level[4:0]), 32'h1f);
      wr(ba(`RCRB_OFF_BUCK3_CTRL) | 9'h002, 8'h00, `RCRB_RESP_SLVERR);
      rd(ba(`RCRB_OFF_BUCK3_CTRL) | 9'h002, 8'h00, `RCRB_RESP_SLVERR);
      wr(ba(8'h44), 8'hff, `RCRB_RESP_SLVERR);
      rd(ba(8'h44), 8'h00, `RCRB_RESP_SLVERR);
      @(negedge aclk);
      chk(32'(buck3_forced_switching), 32'(fv[4][6]));
      wr(ba(`RCRB_OFF_BUCK3_CTRL), 8'h40);
      repeat (2) @(negedge aclk);
      chk(32'({buck3_forced_switching, buck3_on, buck3_discharge_on}), 32'h5);
      wr(ba(`RCRB_OFF_BUCK3_CTRL), 8'h80);
      @(negedge aclk);
      chk(32'({buck3_forced_switching, buck3_discharge_on}), 32'h0);
      @(posedge aclk);
      fv <= ~fv;
      rst_chk;
      d = fv[9] | 8'h10;
      wr(ba(`RCRB_OFF_LIN1_CTRL), d);
      @(negedge aclk);
      chk(32'(linreg_switch_mode), 32'({fv[13][4], 1'b1}));
      rd(ba(`RCRB_OFF_LIN1_CTRL), d & 8'h1f);
      stop_test;
   end
endmodule
